// File: rtl/tick_pkg.sv
package tick_pkg;

    // Divider chain and rate taps
    localparam int STAGE_COUNT = 15;
    localparam int RATE_COUNT  = 8;
    localparam int RATE_WIDTH  = 3;
    localparam int OSC_HZ      = 32768;

    // Counter bit whose rising edge marks an event; ratio is 2 ** (bit + 1)
    localparam logic [3:0] TAP_BIT [0:RATE_COUNT-1] =
        '{4'hE, 4'hC, 4'hA, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2};
    localparam int DIVIDE_RATIO [0:RATE_COUNT-1] =
        '{32768, 8192, 2048, 128, 64, 32, 16, 8};

    // Bus geometry
    localparam int DATA_WIDTH = 32;
    localparam int ADDR_WIDTH = 8;

    // Register byte offsets
    localparam logic [ADDR_WIDTH-1:0] CONTROL_OFFSET      = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] EVENT_STATUS_OFFSET = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] EVENT_MASK_OFFSET   = 8'h08;

    // Control register fields
    localparam int PEND_BIT   = 7;
    localparam int RATE_LSB   = 4;
    localparam int ACK_BIT    = 3;
    localparam int IRQEN_BIT  = 2;
    localparam int ENABLE_BIT = 1;

    // Reset values
    localparam logic [RATE_WIDTH-1:0] RATE_RESET  = 3'h0;
    localparam int                    EVENT_COUNT = 2;
    localparam logic [1:0]            EVENT_RESET = 2'h0;

    // Event bit positions in status and mask
    localparam int EV_TICK = 0;
    localparam int EV_WAKE = 1;

    // Bus slave phases
    typedef enum logic {
        PHASE_IDLE,
        PHASE_ACCESS
    } apb_phase_type;

endpackage

// File: rtl/regbus_if.sv
`timescale 1ns/1ps
interface regbus_if;
    import tick_pkg::*;

    logic [ADDR_WIDTH-1:0] regAddr;
    logic [DATA_WIDTH-1:0] writeData;
    logic                  writeFire;
    logic                  readFire;
    logic [DATA_WIDTH-1:0] readCaptured;
    logic [DATA_WIDTH-1:0] readValue;
    logic                  addrValid;
    logic                  accessBlocked;

    // Bus slave end
    modport bus_side (
        output regAddr, writeData, writeFire, readFire, readCaptured,
        input  readValue, addrValid, accessBlocked
    );

    // Register file end
    modport core_side (
        input  regAddr, writeData, writeFire, readFire, readCaptured,
        output readValue, addrValid, accessBlocked
    );
endinterface

// File: rtl/apb_reg_port.sv
`timescale 1ns/1ps
module apb_reg_port
    import tick_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [DATA_WIDTH-1:0] pwdata,
    output      logic [DATA_WIDTH-1:0] prdata,
    output      logic                  pready,
    output      logic                  pslverr,
    // Register file side
    regbus_if.bus_side                 bus
);
    apb_phase_type         phase_reg;
    logic [DATA_WIDTH-1:0] prdata_reg;
    logic                  pready_reg;
    logic                  pslverr_reg;
    logic                  completing;

    // Read data is captured in setup so it is stable through the access phase
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_reg   <= PHASE_IDLE;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            case (phase_reg)
                PHASE_IDLE: begin
                    if (psel && !penable) begin
                        phase_reg   <= PHASE_ACCESS;
                        pready_reg  <= 1'b1;
                        pslverr_reg <= !bus.addrValid || bus.accessBlocked;
                        prdata_reg  <= (bus.addrValid && !bus.accessBlocked && !pwrite)
                                       ? bus.readValue : '0;
                    end
                end
                PHASE_ACCESS: begin
                    if (completing || !psel) begin
                        phase_reg   <= PHASE_IDLE;
                        pready_reg  <= 1'b0;
                        pslverr_reg <= 1'b0;
                    end
                end
                default: begin
                    phase_reg  <= PHASE_IDLE;
                    pready_reg <= 1'b0;
                end
            endcase
        end
    end

    // Side effects happen only at the completing edge of an accepted transfer
    assign completing       = (phase_reg == PHASE_ACCESS) && psel && penable && pready_reg;
    assign bus.writeFire    = completing && pwrite && !pslverr_reg && !bus.accessBlocked;
    assign bus.readFire     = completing && !pwrite && !pslverr_reg;
    assign bus.regAddr      = paddr;
    assign bus.writeData    = pwdata;
    assign bus.readCaptured = prdata_reg;
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;

    // Access whose setup phase falls in low power is refused with an error
    property p_blocked_err;
        @(posedge clock) disable iff (reset)
        (phase_reg == PHASE_IDLE && psel && !penable && bus.accessBlocked)
            |=> (pready_reg && pslverr_reg && prdata_reg == '0);
    endproperty
    a_blocked_err: assert property (p_blocked_err)
        else $error("blocked access not refused");
endmodule

// File: rtl/tick_divider.sv
`timescale 1ns/1ps
module tick_divider
    import tick_pkg::*;
#(
    parameter int STAGES = STAGE_COUNT
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // Control
    input  wire logic                  clear,
    input  wire logic                  advance,
    input  wire logic [RATE_WIDTH-1:0] rateSelect,
    // Event
    output      logic                  overflowPulse
);
    logic [STAGES-1:0]     count_reg;
    logic [STAGES-1:0]     countNext;
    logic [RATE_COUNT-1:0] tapRise;
    logic                  overflow_reg;

    // Refuse chains too short for the deepest tap
    if (STAGES < STAGE_COUNT) begin : g_bad_stages
        $error("tick_divider: STAGES below the deepest tap");
    end

    assign countNext = STAGES'(count_reg + 1'b1);

    // Rising edge of bit k-1 at ratio 2**k: first event after half a period
    for (genvar i = 0; i < RATE_COUNT; i++) begin : g_tap
        if (DIVIDE_RATIO[i] != (2 ** (int'(TAP_BIT[i]) + 1))) begin : g_bad_tap
            $error("tick_divider: tap table inconsistent");
        end
        assign tapRise[i] = !count_reg[TAP_BIT[i]] && countNext[TAP_BIT[i]];
    end

    // Fifteen-stage chain, held at zero while disabled
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_reg    <= '0;
            overflow_reg <= 1'b0;
        end else if (clear) begin
            count_reg    <= '0;
            overflow_reg <= 1'b0;
        end else if (advance) begin
            count_reg    <= countNext;
            overflow_reg <= tapRise[rateSelect];
        end else begin
            overflow_reg <= 1'b0;
        end
    end

    assign overflowPulse = overflow_reg;

    property p_clear_zero;
        @(posedge clock) disable iff (reset)
        clear |=> (count_reg == '0 && !overflow_reg);
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("counter not held at zero");

    property p_halt_stable;
        @(posedge clock) disable iff (reset)
        (!clear && !advance) |=> ($stable(count_reg) && !overflow_reg);
    endproperty
    a_halt_stable: assert property (p_halt_stable)
        else $error("counter moved without an oscillator tick");
endmodule

// File: rtl/periodic_tick_unit.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module periodic_tick_unit
    import tick_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  reset,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [DATA_WIDTH-1:0] pwdata,
    output      logic [DATA_WIDTH-1:0] prdata,
    output      logic                  pready,
    output      logic                  pslverr,
    // Oscillator and low-power state
    input  wire logic                  crystalClock,
    input  wire logic                  waitMode,
    input  wire logic                  stopMode,
    input  wire logic                  oscRunInStop,
    // Interrupt
    output      logic                  irq
);
    regbus_if bus ();

    // Oscillator synchroniser and edge detector
    logic                   crystalSync1_reg;
    logic                   crystalSync2_reg;
    logic                   crystalLast_reg;
    logic                   crystalTick;

    // Control register state
    logic                   tickEnable_reg;
    logic                   tickIrqEnable_reg;
    logic [RATE_WIDTH-1:0]  rateSelect_reg;
    logic                   pendingFlag_reg;

    // Event status and mask
    logic [EVENT_COUNT-1:0] eventStatus_reg;
    logic [EVENT_COUNT-1:0] eventStatus_next;
    logic [EVENT_COUNT-1:0] eventMask_reg;
    logic [EVENT_COUNT-1:0] eventRaise;
    logic [EVENT_COUNT-1:0] statusReadClear;

    // Datapath glue
    logic                   halted;
    logic                   advance;
    logic                   overflowPulse;
    logic                   controlWrite;
    logic                   ackWrite;
    logic                   irq_reg;
    logic [DATA_WIDTH-1:0]  readValue;
    logic                   addrValid;

    apb_reg_port u_apb (
        .clock   (clock),
        .reset   (reset),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus.bus_side)
    );

    // Two flops before anything looks at the oscillator level
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            crystalSync1_reg <= 1'b0;
            crystalSync2_reg <= 1'b0;
            crystalLast_reg  <= 1'b0;
        end else begin
            crystalSync1_reg <= crystalClock;
            crystalSync2_reg <= crystalSync1_reg;
            crystalLast_reg  <= crystalSync2_reg;
        end
    end

    // One bus cycle per oscillator rising edge; oscillator must be well below clock/2
    assign crystalTick = crystalSync2_reg && !crystalLast_reg;

    // Stop without a running oscillator freezes the chain; wait leaves it running
    assign halted  = stopMode && !oscRunInStop;
    assign advance = crystalTick && tickEnable_reg && !halted;

    tick_divider #(
        .STAGES (STAGE_COUNT)
    ) u_divider (
        .clock         (clock),
        .reset         (reset),
        .clear         (!tickEnable_reg),
        .advance       (advance),
        .rateSelect    (rateSelect_reg),
        .overflowPulse (overflowPulse)
    );

    // Write decode; the bus port already refuses writes in wait and stop
    assign controlWrite = bus.writeFire && (bus.regAddr == CONTROL_OFFSET);
    assign ackWrite     = controlWrite && bus.writeData[ACK_BIT];

    // Control fields; the rate is taken as written, even while enabled
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tickEnable_reg    <= 1'b0;
            tickIrqEnable_reg <= 1'b0;
            rateSelect_reg    <= RATE_RESET;
        end else if (controlWrite) begin
            tickEnable_reg    <= bus.writeData[ENABLE_BIT];
            tickIrqEnable_reg <= bus.writeData[IRQEN_BIT];
            rateSelect_reg    <= bus.writeData[RATE_LSB +: RATE_WIDTH];
        end
    end

    // Pending flag: an overflow in the acknowledge cycle wins so no tick is lost
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pendingFlag_reg <= 1'b0;
        end else if (overflowPulse) begin
            pendingFlag_reg <= 1'b1;
        end else if (ackWrite) begin
            pendingFlag_reg <= 1'b0;
        end
    end

    // Sticky events; only bits actually returned by the read are cleared
    assign eventRaise[EV_TICK] = overflowPulse;
    assign eventRaise[EV_WAKE] = overflowPulse && stopMode;
    assign statusReadClear     = (bus.readFire && bus.regAddr == EVENT_STATUS_OFFSET)
                                 ? bus.readCaptured[EVENT_COUNT-1:0] : '0;
    assign eventStatus_next    = (eventStatus_reg & ~statusReadClear) | eventRaise;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            eventStatus_reg <= EVENT_RESET;
        end else begin
            eventStatus_reg <= eventStatus_next;
        end
    end

    // Event mask
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            eventMask_reg <= EVENT_RESET;
        end else if (bus.writeFire && bus.regAddr == EVENT_MASK_OFFSET) begin
            eventMask_reg <= bus.writeData[EVENT_COUNT-1:0];
        end
    end

    // Registered request trails its cause by one cycle, which keeps the pin glitch free
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (pendingFlag_reg && tickIrqEnable_reg)
                       || (|(eventStatus_reg & eventMask_reg));
        end
    end

    assign irq = irq_reg;

    // Read mux; the acknowledge bit and unused bits read as zero
    always_comb begin
        readValue = '0;
        addrValid = 1'b0;
        case (bus.regAddr)
            CONTROL_OFFSET: begin
                addrValid                           = 1'b1;
                readValue[PEND_BIT]                 = pendingFlag_reg;
                readValue[RATE_LSB +: RATE_WIDTH]   = rateSelect_reg;
                readValue[IRQEN_BIT]                = tickIrqEnable_reg;
                readValue[ENABLE_BIT]               = tickEnable_reg;
            end
            EVENT_STATUS_OFFSET: begin
                addrValid                    = 1'b1;
                readValue[EVENT_COUNT-1:0]   = eventStatus_reg;
            end
            EVENT_MASK_OFFSET: begin
                addrValid                    = 1'b1;
                readValue[EVENT_COUNT-1:0]   = eventMask_reg;
            end
            default: begin
                addrValid = 1'b0;
            end
        endcase
    end

    assign bus.readValue     = readValue;
    assign bus.addrValid     = addrValid;
    assign bus.accessBlocked = waitMode || stopMode;

    // Checks
    property p_pend_set;
        @(posedge clock) disable iff (reset)
        overflowPulse |=> pendingFlag_reg;
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("overflow did not set pending flag");

    property p_pend_hold;
        @(posedge clock) disable iff (reset)
        (pendingFlag_reg && !ackWrite) |=> pendingFlag_reg;
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("pending flag dropped without acknowledge");

    property p_ack_clear;
        @(posedge clock) disable iff (reset)
        (ackWrite && !overflowPulse) |=> !pendingFlag_reg;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("acknowledge did not clear pending flag");

    property p_ack_reads_zero;
        @(posedge clock) disable iff (reset)
        (bus.readFire && bus.regAddr == CONTROL_OFFSET) |-> !bus.readCaptured[ACK_BIT];
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("acknowledge bit read as one");

    property p_irq_follow;
        @(posedge clock) disable iff (reset)
        (pendingFlag_reg && tickIrqEnable_reg) |=> irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("interrupt not raised for enabled pending flag");

    property p_irq_quiet;
        @(posedge clock) disable iff (reset)
        (!tickIrqEnable_reg && (eventStatus_reg & eventMask_reg) == '0) |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt raised while disabled");

    property p_off_quiet;
        @(posedge clock) disable iff (reset)
        !tickEnable_reg |=> !overflowPulse;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("overflow while timebase disabled");

    property p_halt_quiet;
        @(posedge clock) disable iff (reset)
        halted |=> !overflowPulse;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("overflow in stop without oscillator");

    property p_synced_tick;
        @(posedge clock) disable iff (reset)
        overflowPulse |-> ($past(crystalSync2_reg) && !$past(crystalLast_reg));
    endproperty
    a_synced_tick: assert property (p_synced_tick)
        else $error("overflow not caused by a synchronised edge");

    c_overflow: cover property (@(posedge clock) disable iff (reset) overflowPulse);
    c_irq_rise: cover property (@(posedge clock) disable iff (reset) $rose(irq));
    c_ack_clear: cover property (@(posedge clock) disable iff (reset)
        pendingFlag_reg && ackWrite);
    c_stop_wake: cover property (@(posedge clock) disable iff (reset)
        overflowPulse && stopMode);
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import tick_pkg::*;
;
    logic                  clock;
    logic                  reset;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [DATA_WIDTH-1:0] pwdata;
    logic [DATA_WIDTH-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  crystalClock = 1'b0;
    logic                  waitMode;
    logic                  stopMode;
    logic                  oscRunInStop;
    logic                  irq;
    logic [2:0]            xtalDiv      = 3'h0;
    int                    cycleCount   = 0;
    int                    n_mismatch;
    int                    num_checks;

    periodic_tick_unit periodic_tick_unit_i (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystalClock(crystalClock), .waitMode(waitMode),
        .stopMode(stopMode), .oscRunInStop(oscRunInStop), .irq(irq)
    );

    // Bus clock, 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Crystal at clock/8, derived from the bus clock so every period is an exact cycle count
    always @(posedge clock) begin
        xtalDiv      <= xtalDiv + 3'h1;
        crystalClock <= xtalDiv[2];
        cycleCount   <= cycleCount + 1;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic isWrite, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= isWrite;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            n_mismatch++;
            give_verdict();
        end else begin
            rdata = prdata;
            err   = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic        e;
        apb(1'b1, addr, data, d, e);
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp, input logic expErr);
        logic [31:0] d;
        logic        e;
        apb(1'b0, addr, 32'h0, d, e);
        check(d, exp);
        check({31'h0, e}, {31'h0, expErr});
    endtask

    function automatic logic [31:0] ctrl(input logic [2:0] rate, input logic ack,
                                         input logic ie, input logic en);
        ctrl = '0;
        ctrl[RATE_LSB +: RATE_WIDTH] = rate;
        ctrl[ACK_BIT]    = ack;
        ctrl[IRQEN_BIT]  = ie;
        ctrl[ENABLE_BIT] = en;
    endfunction

    // Sampled on the falling edge, where registered outputs have settled
    task automatic wait_irq(input logic level, input int limit, output logic found);
        found = 1'b0;
        for (int k = 0; k < limit && !found; k++) begin
            @(negedge clock);
            if (irq === level) found = 1'b1;
        end
    endtask

    task automatic reset_values();
        rd_check(CONTROL_OFFSET, 32'h0, 1'b0);
        rd_check(EVENT_STATUS_OFFSET, 32'h0, 1'b0);
        rd_check(EVENT_MASK_OFFSET, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h0);
    endtask

    // Pending flag set from the bus and acknowledge both must read back as zero
    task automatic access_kinds();
        for (int r = 0; r < RATE_COUNT; r++) begin
            wr(CONTROL_OFFSET, ctrl(3'(r), 1'b1, 1'b1, 1'b0) | 32'h80);
            rd_check(CONTROL_OFFSET, ctrl(3'(r), 1'b0, 1'b1, 1'b0), 1'b0);
        end
        wr(CONTROL_OFFSET, 32'h0);
        rd_check(8'h0C, 32'h0, 1'b1);
        wr(EVENT_MASK_OFFSET, 32'h3);
        rd_check(EVENT_MASK_OFFSET, 32'h3, 1'b0);
        wr(EVENT_MASK_OFFSET, 32'h0);
    endtask

    // Each fast rate: first event near half a period, then exactly one period apart
    task automatic sweep();
        logic found;
        int   n;
        int   tEn;
        int   tFirst;
        for (int code = 2; code < RATE_COUNT; code++) begin
            n = DIVIDE_RATIO[code];
            // Acknowledge while disabling, so the previous pass leaves no pending flag
            wr(CONTROL_OFFSET, ctrl(3'(code), 1'b1, 1'b1, 1'b0));
            wr(CONTROL_OFFSET, ctrl(3'(code), 1'b0, 1'b1, 1'b1));
            tEn = cycleCount;
            wait_irq(1'b1, 8 * n + 100, found);
            tFirst = cycleCount;
            check({31'h0, found && (tFirst - tEn >= 4 * n - 8) && (tFirst - tEn <= 4 * n + 16)},
                  32'h1);
            rd_check(CONTROL_OFFSET, ctrl(3'(code), 1'b0, 1'b1, 1'b1) | 32'h80, 1'b0);
            wr(CONTROL_OFFSET, ctrl(3'(code), 1'b1, 1'b1, 1'b1));
            wait_irq(1'b0, 10, found);
            check({31'h0, found}, 32'h1);
            wait_irq(1'b1, 8 * n + 100, found);
            check(32'(cycleCount - tFirst), 32'(8 * n));
        end
        wr(CONTROL_OFFSET, ctrl(3'h0, 1'b1, 1'b0, 1'b0));
    endtask

    // Pending without irq enable stays silent; status and mask give a second path
    task automatic mask_path();
        logic found;
        wr(CONTROL_OFFSET, ctrl(3'h3, 1'b0, 1'b0, 1'b1));
        wait_irq(1'b1, 2048, found);
        check({31'h0, found}, 32'h0);
        rd_check(CONTROL_OFFSET, ctrl(3'h3, 1'b0, 1'b0, 1'b1) | 32'h80, 1'b0);
        wr(CONTROL_OFFSET, ctrl(3'h3, 1'b1, 1'b0, 1'b1));
        rd_check(CONTROL_OFFSET, ctrl(3'h3, 1'b0, 1'b0, 1'b1), 1'b0);
        rd_check(EVENT_STATUS_OFFSET, 32'h1, 1'b0);
        rd_check(EVENT_STATUS_OFFSET, 32'h0, 1'b0);
        wr(EVENT_MASK_OFFSET, 32'h1);
        wait_irq(1'b1, 1100, found);
        check({31'h0, found}, 32'h1);
        rd_check(EVENT_STATUS_OFFSET, 32'h1, 1'b0);
        wait_irq(1'b0, 5, found);
        check({31'h0, found}, 32'h1);
        wr(EVENT_MASK_OFFSET, 32'h0);
        wr(CONTROL_OFFSET, 32'h0);
    endtask

    // Wait and stop: bus refused, counting continues only where the oscillator runs
    task automatic low_power();
        logic found;
        // Acknowledge first, so the wait-mode interrupt can only come from a fresh tick
        wr(CONTROL_OFFSET, ctrl(3'h7, 1'b1, 1'b1, 1'b1));
        @(posedge clock);
        waitMode <= 1'b1;
        rd_check(CONTROL_OFFSET, 32'h0, 1'b1);
        wait_irq(1'b1, 200, found);
        check({31'h0, found}, 32'h1);
        @(posedge clock);
        waitMode <= 1'b0;
        wr(CONTROL_OFFSET, ctrl(3'h7, 1'b1, 1'b1, 1'b1));
        @(posedge clock);
        stopMode     <= 1'b1;
        oscRunInStop <= 1'b1;
        wait_irq(1'b0, 10, found);
        wait_irq(1'b1, 200, found);
        check({31'h0, found}, 32'h1);
        rd_check(CONTROL_OFFSET, 32'h0, 1'b1);
        @(posedge clock);
        stopMode <= 1'b0;
        rd_check(EVENT_STATUS_OFFSET, 32'h3, 1'b0);
        wr(CONTROL_OFFSET, ctrl(3'h7, 1'b1, 1'b1, 1'b1));
        @(posedge clock);
        stopMode     <= 1'b1;
        oscRunInStop <= 1'b0;
        wait_irq(1'b1, 300, found);
        check({31'h0, found}, 32'h0);
        @(posedge clock);
        stopMode <= 1'b0;
        // Ticks unneeded: timebase off before waiting, so wait mode stays silent
        wr(CONTROL_OFFSET, ctrl(3'h7, 1'b1, 1'b1, 1'b0));
        @(posedge clock);
        waitMode <= 1'b1;
        wait_irq(1'b1, 200, found);
        check({31'h0, found}, 32'h0);
        @(posedge clock);
        waitMode <= 1'b0;
    endtask

    // Main sequence; every input has a value from time zero
    initial begin
        reset        = 1'b1;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        waitMode     = 1'b0;
        stopMode     = 1'b0;
        oscRunInStop = 1'b0;
        n_mismatch   = 0;
        num_checks   = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        reset_values();
        access_kinds();
        sweep();
        mask_path();
        low_power();
        give_verdict();
    end
endmodule
